// file: rtl/smc_pkg.sv
// package for the asynchronous byte memory host controller
package smc_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;

    // timing figures in ns, worst-case grade
    localparam int CLK_PERIOD_NS  = 20;
    localparam int T_CYCLE_NS     = 70;
    localparam int T_ACCESS_NS    = 70;
    localparam int T_WPULSE_NS    = 60;
    localparam int T_SETUP_D_NS   = 30;
    localparam int T_FLOAT_NS     = 25;
    localparam int T_RECOVER_NS   = 70;

    // least times round up to whole cycles, the read one cycle more
    localparam int RD_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WR_CYC  = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DS_CYC  = (T_SETUP_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;

    // user request carrier
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } smc_req_t;

    // memory strobe carrier, all active levels as on the pins
    typedef struct packed {
        logic sel_n;
        logic sel;
        logic oe_n;
        logic we_n;
    } smc_strb_t;

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP, ST_STBY, ST_RECOVER} smc_st_t;

endpackage

// file: rtl/smc_host.sv
// host controller driving an asynchronous 1M x 8 static memory
// Function
// RL1: memory holds 1M bytes, 20-bit address, 8-bit data
// RL2: write only with both selects and strobe active
// RL3: write starts all active, ends on one release
// RL4: host holds data around the write-ending edge
// RL5: read with strobe high, selected, output enabled
// RL6: memory floats data after deselect
// RL7: memory floats data while strobe low
// RL8: memory updates read data on address change
// RL9: host sets address no later than select
// RL10: host waits a cycle time after retention standby
// RL11: selected, output disabled: memory stays floated
// RL12: deselected memory ignores controls, enters standby
`timescale 1ns/1ps
module smc_host
    import smc_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic              REQ_VALID,
    input  wire smc_req_t          REQ,
    output logic                   REQ_READY,
    output logic                   RD_VALID,
    output logic [DATA_W-1:0]      RD_DATA,
    input  wire logic              STANDBY,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output smc_strb_t              MEM_STRB,
    output logic [DATA_W-1:0]      MEM_DQ_O,
    output logic                   MEM_DQ_OE,
    input  wire logic [DATA_W-1:0] MEM_DQ_I
);

    smc_st_t       state_r;
    logic [3:0]    cnt_r;
    logic          done;
    logic          take;

    assign done = (cnt_r == CNT_ONE);

    // a request is taken only on a ready handshake, which wins over standby
    assign take = (state_r == ST_IDLE) && REQ_VALID && REQ_READY;

    // sequencer
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        state_r <= REQ.wr ? ST_WRITE : ST_READ;
                        cnt_r   <= REQ.wr ? 4'(WR_CYC) : 4'(RD_CYC);
                    end else if (STANDBY) begin
                        state_r <= ST_STBY;
                    end
                end
                ST_READ, ST_WRITE: begin
                    cnt_r <= cnt_r - CNT_ONE;
                    if (done) begin
                        state_r <= ST_GAP;
                        cnt_r   <= 4'(GAP_CYC);
                    end
                end
                ST_GAP: begin
                    cnt_r <= cnt_r - CNT_ONE;
                    if (done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_STBY: begin
                    if (!STANDBY) begin
                        state_r <= ST_RECOVER;
                        cnt_r   <= 4'(REC_CYC); // RL10
                    end
                end
                ST_RECOVER: begin
                    cnt_r <= cnt_r - CNT_ONE;
                    if (done) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // address and write data latch at acceptance, held across the cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            MEM_ADDR <= '0;
            MEM_DQ_O <= '0;
        end else if (take) begin
            MEM_ADDR <= REQ.addr; // RL9
            MEM_DQ_O <= REQ.wdata; // RL4
        end
    end

    // strobes: select asserted together with address, released together
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            MEM_STRB <= '{sel_n: 1'b1, sel: 1'b0, oe_n: 1'b1, we_n: 1'b1};
            MEM_DQ_OE <= 1'b0;
        end else if (take) begin
            MEM_STRB.sel_n <= 1'b0; // RL2
            MEM_STRB.sel   <= 1'b1;
            MEM_STRB.oe_n  <= REQ.wr; // RL5
            MEM_STRB.we_n  <= !REQ.wr; // RL3
            MEM_DQ_OE      <= REQ.wr;
        end else if ((state_r == ST_READ || state_r == ST_WRITE) && done) begin
            // strobe and selects end together, data held one more cycle
            MEM_STRB  <= '{sel_n: 1'b1, sel: 1'b0, oe_n: 1'b1, we_n: 1'b1}; // RL3
            MEM_DQ_OE <= MEM_DQ_OE; // RL4
        end else if (state_r == ST_GAP) begin
            MEM_DQ_OE <= 1'b0;
        end else if (state_r == ST_STBY) begin
            MEM_STRB.sel <= 1'b0; // RL12
        end
    end

    // read capture on the last strobed cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RD_VALID <= 1'b0;
            RD_DATA  <= '0;
        end else begin
            RD_VALID <= (state_r == ST_READ) && done; // RL5
            if ((state_r == ST_READ) && done) begin
                RD_DATA <= MEM_DQ_I;
            end
        end
    end

    // ready registered to rise on the same edge as the entry to idle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REQ_READY <= 1'b0;
        end else begin
            REQ_READY <= (state_r == ST_IDLE && !take && !STANDBY)
                       || ((state_r == ST_GAP || state_r == ST_RECOVER) && done);
        end
    end

    // host never drives data while memory output is enabled
    property p_no_contention;
        @(posedge REF_CLK) disable iff (RST) !(MEM_DQ_OE && !MEM_STRB.oe_n);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention"); // RL7

    property p_write_pulse;
        @(posedge REF_CLK) disable iff (RST)
            $fell(MEM_STRB.we_n) |-> (!MEM_STRB.we_n && !MEM_STRB.sel_n)[*3];
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write pulse short"); // RL3

    property p_data_hold;
        @(posedge REF_CLK) disable iff (RST)
            $rose(MEM_STRB.we_n) |-> MEM_DQ_OE && $stable(MEM_DQ_O);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data hold lost"); // RL4

    property p_addr_stable;
        @(posedge REF_CLK) disable iff (RST)
            !MEM_STRB.sel_n && !$rose(!MEM_STRB.sel_n) |-> $stable(MEM_ADDR);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved"); // RL9

    property p_read_done;
        @(posedge REF_CLK) disable iff (RST)
            $fell(MEM_STRB.oe_n) |-> ##[4:5] RD_VALID;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read late"); // RL5

    property p_recover;
        @(posedge REF_CLK) disable iff (RST)
            $fell(STANDBY) && state_r == ST_STBY |-> MEM_STRB.sel_n[*4];
    endproperty
    a_recover: assert property (p_recover) else $error("recovery short"); // RL10

    property p_standby_desel;
        @(posedge REF_CLK) disable iff (RST)
            state_r == ST_STBY |=> !MEM_STRB.sel || MEM_STRB.sel_n;
    endproperty
    a_standby_desel: assert property (p_standby_desel) else $error("standby selected"); // RL12

    property p_both_sel;
        @(posedge REF_CLK) disable iff (RST) MEM_STRB.sel_n == !MEM_STRB.sel || state_r == ST_STBY
            || $past(state_r) == ST_STBY;
    endproperty
    a_both_sel: assert property (p_both_sel) else $error("selects split"); // RL2

    // selection starts only on the edge that takes a ready handshake
    property p_select_after_take;
        @(posedge REF_CLK) disable iff (RST)
            $rose(!MEM_STRB.sel_n) |-> $past(REQ_VALID) && $past(REQ_READY);
    endproperty
    a_select_after_take: assert property (p_select_after_take) else $error("select untaken"); // RL9

    // ready is only offered while the sequencer is idle
    property p_ready_idle;
        @(posedge REF_CLK) disable iff (RST)
            REQ_READY |-> state_r == ST_IDLE;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready while busy"); // RL3

    // during a write the memory output stays disabled and the host drives data
    property p_write_oe;
        @(posedge REF_CLK) disable iff (RST)
            !MEM_STRB.we_n |-> MEM_STRB.oe_n && MEM_DQ_OE;
    endproperty
    a_write_oe: assert property (p_write_oe) else $error("write without data drive"); // RL4

    // a released memory stays deselected through the gap
    property p_gap;
        @(posedge REF_CLK) disable iff (RST)
            $rose(MEM_STRB.sel_n) |-> MEM_STRB.sel_n[*3];
    endproperty
    a_gap: assert property (p_gap) else $error("gap short"); // RL3

    c_read:  cover property (@(posedge REF_CLK) disable iff (RST) RD_VALID);
    c_write: cover property (@(posedge REF_CLK) disable iff (RST) $rose(MEM_STRB.we_n));
    c_stby:  cover property (@(posedge REF_CLK) disable iff (RST) state_r == ST_RECOVER);
    c_enter: cover property (@(posedge REF_CLK) disable iff (RST) state_r == ST_STBY);

endmodule

// file: bench/smc_mem_model.sv
// behavioural byte memory answering the host controller's strobes
`timescale 1ns/1ps
module smc_mem_model
    import smc_pkg::*;
(
    input  wire logic [ADDR_W-1:0] a,
    input  wire smc_strb_t         s,
    input  wire logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0]      q
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic              sel_w;
    logic              wr_w;
    logic              rd_w;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] q_drv = 8'h00;
    // both selects needed, otherwise every other control is ignored
    assign sel_w = !s.sel_n && s.sel;
    assign wr_w  = sel_w && !s.we_n;
    assign rd_w  = sel_w && s.we_n && !s.oe_n;
    // follow address and data while the write overlap lasts
    always @* if (wr_w) begin
        wa = a;
        wd = d;
    end
    // commit on whichever release ends the overlap
    always @(negedge wr_w) mem[wa] = wd;
    // read data follows the address while selected and enabled
    always @* if (rd_w) begin
        q_drv = mem.exists(a) ? mem[a] : 8'h00;
    end
    // floated lines show the inverse of the last driven byte
    assign q = rd_w ? q_drv : ~q_drv;
endmodule

// file: bench/smc_host_tb.sv
// self-checking bench for the asynchronous byte memory host controller
`timescale 1ns/1ps
module smc_host_tb;
    import smc_pkg::*;
    logic              ref_clk, rst, req_valid, standby;
    logic              req_ready, rd_valid, dq_oe;
    smc_req_t          req;
    smc_strb_t         mem_strb;
    logic [DATA_W-1:0] rd_data, dq_o, dq_i;
    logic [ADDR_W-1:0] mem_addr;
    int                err_count, checked, cycles;
    smc_host smc_host_inst (.REF_CLK(ref_clk), .RST(rst), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .STANDBY(standby),
        .MEM_ADDR(mem_addr), .MEM_STRB(mem_strb), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe),
        .MEM_DQ_I(dq_i));
    smc_mem_model smc_mem_model_inst (.a(mem_addr), .s(mem_strb), .d(dq_o), .q(dq_i));
    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request held until taken
    task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = {wr, a, wd};
        // ready seen at a falling edge is what the next rising edge samples
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        chk("req_ready", 8'h01, {7'h00, req_ready});
        @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        access(1'b0, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
        chk("read cycles", 8'(RD_CYC), 8'(n));
        chk("rd_data", exp, rd_data);
        @(negedge ref_clk);
        chk("rd_valid pulse", 8'h00, {7'h00, rd_valid});
    endtask
    task automatic t_basic();
        access(1'b1, 20'h0_0000, 8'hA5);
        rd_chk(20'h0_0000, 8'hA5);
        $display("test basic done");
    endtask
    task automatic t_edges();
        access(1'b1, 20'hF_FFFF, 8'h5A);
        access(1'b1, 20'h0_0001, 8'h96);
        rd_chk(20'hF_FFFF, 8'h5A);
        rd_chk(20'h0_0001, 8'h96);
        $display("test edges done");
    endtask
    task automatic t_overwrite();
        access(1'b1, 20'h0_0005, 8'h3C);
        access(1'b1, 20'h0_0005, 8'hC3);
        rd_chk(20'h0_0005, 8'hC3);
        $display("test overwrite done");
    endtask
    task automatic t_standby();
        @(negedge ref_clk);
        standby = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("sel pair", 8'h02, {6'h00, mem_strb.sel_n, mem_strb.sel});
        chk("ready", 8'h00, {7'h00, req_ready});
        standby = 1'b0;
        rd_chk(20'h0_0000, 8'hA5);
        $display("test standby done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        standby = 1'b0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_basic();
        t_edges();
        t_overwrite();
        t_standby();
        complete_run();
    end
endmodule
